// file: logic/acms_clkgen.sv
// phase generator: one count per 512fs tick, from the core divider or from master clock input edges
`timescale 1ns/100ps
module acms_clkgen
  import acms_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic use_ext,
  input wire logic [7:0] div,
  input wire logic [2:0] edges,
  input wire logic master_clock_input,
  // phase out
  output logic [8:0] phase
);
  logic master_clock_input_q, master_clock_input_d;
  logic [7:0] div_q, div_d;
  logic [1:0] edg_q, edg_d;
  logic [8:0] ph_q, ph_d;
  logic tick;

  always_comb
  begin
    master_clock_input_d = master_clock_input;
    div_d = div_q;
    edg_d = edg_q;
    tick = 1'b0;
    if (use_ext)
    begin
      div_d = 8'h00;
      if (master_clock_input != master_clock_input_q)
      begin
        if ({1'b0, edg_q} >= edges - 3'h1)
        begin
          edg_d = 2'h0;
          tick = 1'b1;
        end
        else
          edg_d = edg_q + 2'h1;
      end
    end
    else if (div != 8'h00)
    begin
      edg_d = 2'h0;
      if (div_q >= div - 8'h01)
      begin
        div_d = 8'h00;
        tick = 1'b1;
      end
      else
        div_d = div_q + 8'h01;
    end
    ph_d = tick ? ph_q + 9'h001 : ph_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      master_clock_input_q <= 1'b0;
      div_q <= 8'h00;
      edg_q <= 2'h0;
      ph_q <= 9'h000;
    end
    else
    begin
      master_clock_input_q <= master_clock_input_d;
      div_q <= div_d;
      edg_q <= edg_d;
      ph_q <= ph_d;
    end
  end

  assign phase = ph_q;
endmodule

// file: logic/acms_lock.sv
// lock timer: clocks count as valid only after the limit has run out since the last restart
`timescale 1ns/100ps
module acms_lock
  import acms_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic [31:0] limit,
  // status
  output logic valid
);
  logic [31:0] cnt_q, cnt_d;
  logic done_q, done_d;

  always_comb
  begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (!run || restart)
    begin
      cnt_d = 32'h0000_0000;
      done_d = 1'b0;
    end
    else if (!done_q)
    begin
      cnt_d = cnt_q + 32'h0000_0001;
      if (cnt_q >= limit - 32'h0000_0001)
        done_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign valid = done_q;
endmodule

// file: logic/acms_pkg.sv
// package for the audio clock mode select block: map, fields, timing and decode helpers
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// - The clock mode follows the PLL power bit and master select bit: 11 PLL master, 10 PLL slave, 00 external slave, 01 external master.
// - In both external modes the PLL reference field is ignored and the master clock input ratio comes from rate select bits 1 and 0.
// - With the master clock output enable at 0 the master clock output pin is low in every mode, and at 1 in a PLL mode
//   it carries the divider's frequency once the PLL has locked, and toggles every cycle before.
// - PLL modes with a master clock input reference expect the frequency named by the reference field, and PLL slave with a frame or bit clock reference expects that input grounded.
// - With master select at 1 the device drives bit clock and frame clock (frame clock at 1fs), and at 0 the other party drives both, bit clock at 32fs or more.
// - After the power-down pin has been low the device is in slave mode and turns master only when software writes master select to 1.
// - Until master select is 1 the bit clock and frame clock pins stay undriven.
// - With master select 1, PLL power 0 and output enable 1 the master clock output pin carries invalid clocks.
// - With PLL power 1 the PLL makes the clocks from the reference and rate fields, and with the analog third input select at 1 the PLL is unavailable.
// - After PLL power-up or a rate change the clocks count as invalid until the lock time of the selected reference has passed.
// - The reference field decodes 0 as frame clock, 2 and 3 as bit clock at 32fs and 64fs, 4 to 7, 12 and 13 as master clock input rates, others unused.
// - With a master clock input reference the rate field selects the sampling rate, 0 giving 8kHz, codes 8, 9, 12 and 13 unused.
// - With a frame or bit clock reference only rate bits 3, 1 and 0 select the range and bit 2 is ignored.
package acms_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int LOCK_FRM_MS = 160;
  localparam int LOCK_BCK_MS = 4;
  localparam int LOCK_MASTER_CLOCK_INPUT_MS = 40;
  localparam int LOCK_FRM_CYC = LOCK_FRM_MS * (CLK_HZ / 1000);
  localparam int LOCK_BCK_CYC = LOCK_BCK_MS * (CLK_HZ / 1000);
  localparam int LOCK_MASTER_CLOCK_INPUT_CYC = LOCK_MASTER_CLOCK_INPUT_MS * (CLK_HZ / 1000);
  localparam int TICKS_PER_FS = 512;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLKSEL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int CTRL_PLL_ON = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_MASTER_CLOCK_OUTPUT_EN = 2;
  localparam int CTRL_ANALOG_THIRD_INPUT_SELECT = 3;
  localparam int CTRL_BCK64 = 4;
  localparam int CTRL_PS_LSB = 5;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam int SEL_REF_LSB = 0;
  localparam int SEL_RATE_LSB = 4;
  localparam logic [7:0] CLKSEL_RST = 8'h00;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_VALID = 2;
  localparam int ST_REF_LSB = 3;
  localparam int ST_MASTER_CLOCK_INPUT_GND = 5;
  localparam int ST_RATE_BAD = 6;
  localparam int ST_PLL_RUN = 7;
  localparam int ST_BCK_IN = 8;
  localparam int ST_FRM_IN = 9;
  typedef enum logic [1:0] {EXT_SLAVE = 2'b00, EXT_MASTER = 2'b01, PLL_SLAVE = 2'b10, PLL_MASTER = 2'b11} acms_mode_t;
  typedef enum logic [1:0] {REF_FRM = 2'b00, REF_BCK = 2'b01, REF_MASTER_CLOCK_INPUT = 2'b10, REF_NONE = 2'b11} acms_ref_t;
  // reference field decode
  function automatic acms_ref_t acms_ref_src(input logic [3:0] code);
    case (code)
      4'h0: acms_ref_src = REF_FRM;
      4'h2, 4'h3: acms_ref_src = REF_BCK;
      4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd: acms_ref_src = REF_MASTER_CLOCK_INPUT;
      default: acms_ref_src = REF_NONE;
    endcase
  endfunction
  // sampling rate in Hz, zero for unused codes
  function automatic int acms_rate_hz(input logic [3:0] code, input logic master_clock_input_ref);
    logic [2:0] rng;
    rng = {code[3], code[1:0]};
    if (master_clock_input_ref)
    begin
      case (code)
        4'h0: acms_rate_hz = 8000;
        4'h1: acms_rate_hz = 12000;
        4'h2: acms_rate_hz = 16000;
        4'h3: acms_rate_hz = 24000;
        4'h4: acms_rate_hz = 7350;
        4'h5: acms_rate_hz = 11025;
        4'h6: acms_rate_hz = 14700;
        4'h7: acms_rate_hz = 22050;
        4'ha: acms_rate_hz = 32000;
        4'hb: acms_rate_hz = 48000;
        4'he: acms_rate_hz = 29400;
        4'hf: acms_rate_hz = 44100;
        default: acms_rate_hz = 0;
      endcase
    end
    else
    begin
      case (rng)
        3'h0: acms_rate_hz = 8000;
        3'h1: acms_rate_hz = 12000;
        3'h2: acms_rate_hz = 16000;
        3'h3: acms_rate_hz = 24000;
        3'h6: acms_rate_hz = 32000;
        3'h7: acms_rate_hz = 48000;
        default: acms_rate_hz = 0;
      endcase
    end
  endfunction
  // master clock input edges per 512fs tick in external modes
  function automatic logic [2:0] acms_ext_edges(input logic [1:0] code);
    case (code)
      2'h1: acms_ext_edges = 3'h4;
      2'h3: acms_ext_edges = 3'h2;
      default: acms_ext_edges = 3'h1;
    endcase
  endfunction
endpackage

// file: logic/acms_top.sv
// audio clock mode select: wishbone registers, mode decode, serial clock pins and lock tracking
`timescale 1ns/100ps
module acms_top
  import acms_pkg::*;
#(
  parameter int LOCK_FRM = LOCK_FRM_CYC,
  parameter int LOCK_BCK = LOCK_BCK_CYC,
  parameter int LOCK_MASTER_CLOCK_INPUT = LOCK_MASTER_CLOCK_INPUT_CYC
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // power down, low active
  input wire logic POWER_DOWN_PIN_N,
  // master clock pins
  input wire logic MASTER_CLOCK_INPUT,
  output logic MASTER_CLOCK_OUTPUT,
  // bit clock pin
  input wire logic BIT_CLOCK_PIN_I,
  output logic BIT_CLOCK_PIN_O,
  output logic BIT_CLOCK_PIN_OE,
  // frame clock pin
  input wire logic FRAME_CLOCK_PIN_I,
  output logic FRAME_CLOCK_PIN_O,
  output logic FRAME_CLOCK_PIN_OE,
  // status
  output logic [1:0] CLOCK_MODE,
  output logic CLOCKS_VALID,
  output logic PLL_RUNNING
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [6:0] ctrl_q, ctrl_d;
  logic [7:0] sel_q, sel_d;
  logic [7:0] sel_prev_q, sel_prev_d;
  logic run_prev_q, run_prev_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic inv_q, inv_d;
  logic [1:0] mode_q, mode_d;
  logic valid_q, valid_d;
  logic run_q, run_d;
  logic master_clock_output_q, master_clock_output_d;
  logic bck_q, bck_d;
  logic bck_oe_q, bck_oe_d;
  logic frm_q, frm_d;
  logic frm_oe_q, frm_oe_d;
  logic access;
  logic pll_run;
  logic restart;
  logic lock_valid;
  logic [8:0] phase;
  logic [3:0] ref_code;
  logic [3:0] rate_code;
  acms_ref_t ref_src;
  acms_mode_t mode_now;
  int rate_hz;
  logic [7:0] tick_div;
  logic [31:0] lock_limit;
  logic [31:0] status;
  logic clocks_ok;

  assign access = WB_CYC_I && WB_STB_I && !ack_q;
  assign ref_code = sel_q[SEL_REF_LSB +: 4];
  assign rate_code = sel_q[SEL_RATE_LSB +: 4];
  // analog_third_input_select takes the pll away even with power requested
  assign pll_run = ctrl_q[CTRL_PLL_ON] && !ctrl_q[CTRL_ANALOG_THIRD_INPUT_SELECT];
  assign ref_src = acms_ref_src(ref_code);
  assign restart = pll_run && (!run_prev_q || sel_q != sel_prev_q);

  // ----------------------------------------------------------------
  // mode decode and rate selection
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_now = acms_mode_t'({ctrl_q[CTRL_PLL_ON], ctrl_q[CTRL_MASTER]});
    rate_hz = acms_rate_hz(rate_code, ref_src == REF_MASTER_CLOCK_INPUT);
    if (rate_hz == 0)
      tick_div = 8'h00;
    else
      tick_div = 8'(CLK_HZ / (rate_hz * TICKS_PER_FS));
    case (ref_src)
      REF_BCK: lock_limit = 32'(LOCK_BCK);
      REF_MASTER_CLOCK_INPUT: lock_limit = 32'(LOCK_MASTER_CLOCK_INPUT);
      default: lock_limit = 32'(LOCK_FRM);
    endcase
  end

  // ----------------------------------------------------------------
  // clock generation and lock timing
  // ----------------------------------------------------------------
  acms_clkgen u_clkgen
  (
    .clk(CORE_CLK),
    .rst(RESET),
    .use_ext(!pll_run),
    .div(tick_div),
    .edges(acms_ext_edges(rate_code[1:0])),
    .master_clock_input(MASTER_CLOCK_INPUT),
    .phase(phase)
  );

  acms_lock u_lock
  (
    .clk(CORE_CLK),
    .rst(RESET),
    .run(pll_run),
    .restart(restart),
    .limit(lock_limit),
    .valid(lock_valid)
  );

  assign clocks_ok = pll_run ? lock_valid : 1'b1;

  // ----------------------------------------------------------------
  // wishbone register file
  // ----------------------------------------------------------------
  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_MODE_LSB +: 2] = mode_q;
    status[ST_VALID] = valid_q;
    status[ST_REF_LSB +: 2] = ref_src;
    // frame or bit clock reference in pll slave leaves the master clock input grounded
    status[ST_MASTER_CLOCK_INPUT_GND] = pll_run && !ctrl_q[CTRL_MASTER] && (ref_src == REF_FRM || ref_src == REF_BCK);
    status[ST_RATE_BAD] = pll_run && (tick_div == 8'h00 || ref_src == REF_NONE);
    status[ST_PLL_RUN] = run_q;
    status[ST_BCK_IN] = BIT_CLOCK_PIN_I;
    status[ST_FRM_IN] = FRAME_CLOCK_PIN_I;
    ctrl_d = ctrl_q;
    sel_d = sel_q;
    rdat_d = 32'h0000_0000;
    ack_d = access;
    // a write lands at the edge where the master samples ack high
    if (WB_CYC_I && WB_STB_I && ack_q && WB_WE_I && WB_SEL_I[0])
    begin
      if (WB_ADR_I == ADDR_CTRL)
        ctrl_d = WB_DAT_I[6:0];
      else if (WB_ADR_I == ADDR_CLKSEL)
        sel_d = WB_DAT_I[7:0];
    end
    if (access && !WB_WE_I)
    begin
      case (WB_ADR_I)
        ADDR_CTRL: rdat_d = {25'h0000000, ctrl_q};
        ADDR_CLKSEL: rdat_d = {24'h000000, sel_q};
        ADDR_STATUS: rdat_d = status;
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    // power down clears every mode bit, so the device leaves it as a slave
    if (!POWER_DOWN_PIN_N)
    begin
      ctrl_d = CTRL_RST;
      sel_d = CLKSEL_RST;
    end
    sel_prev_d = sel_q;
    run_prev_d = pll_run;
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl_q <= CTRL_RST;
      sel_q <= CLKSEL_RST;
      sel_prev_q <= CLKSEL_RST;
      run_prev_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      sel_q <= sel_d;
      sel_prev_q <= sel_prev_d;
      run_prev_q <= run_prev_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_comb
  begin
    inv_d = !inv_q;
    mode_d = mode_now;
    valid_d = clocks_ok;
    run_d = pll_run;
    bck_oe_d = ctrl_q[CTRL_MASTER];
    frm_oe_d = ctrl_q[CTRL_MASTER];
    // master pins held low until the pll has locked
    bck_d = clocks_ok && phase[3'h3 - {2'h0, ctrl_q[CTRL_BCK64]}];
    frm_d = clocks_ok && phase[8];
    case (mode_now)
      PLL_MASTER, PLL_SLAVE:
      begin
        if (pll_run && lock_valid)
          master_clock_output_d = phase[ctrl_q[CTRL_PS_LSB +: 2]];
        else
          master_clock_output_d = inv_q;
      end
      EXT_MASTER: master_clock_output_d = inv_q;
      EXT_SLAVE: master_clock_output_d = 1'b0;
      default: master_clock_output_d = 1'b0;
    endcase
    if (!ctrl_q[CTRL_MASTER_CLOCK_OUTPUT_EN])
      master_clock_output_d = 1'b0;
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      inv_q <= 1'b0;
      mode_q <= EXT_SLAVE;
      valid_q <= 1'b0;
      run_q <= 1'b0;
      master_clock_output_q <= 1'b0;
      bck_q <= 1'b0;
      bck_oe_q <= 1'b0;
      frm_q <= 1'b0;
      frm_oe_q <= 1'b0;
    end
    else
    begin
      inv_q <= inv_d;
      mode_q <= mode_d;
      valid_q <= valid_d;
      run_q <= run_d;
      master_clock_output_q <= master_clock_output_d;
      bck_q <= bck_d;
      bck_oe_q <= bck_oe_d;
      frm_q <= frm_d;
      frm_oe_q <= frm_oe_d;
    end
  end

  assign WB_DAT_O = rdat_q;
  assign WB_ACK_O = ack_q;
  assign MASTER_CLOCK_OUTPUT = master_clock_output_q;
  assign BIT_CLOCK_PIN_O = bck_q;
  assign BIT_CLOCK_PIN_OE = bck_oe_q;
  assign FRAME_CLOCK_PIN_O = frm_q;
  assign FRAME_CLOCK_PIN_OE = frm_oe_q;
  assign CLOCK_MODE = mode_q;
  assign CLOCKS_VALID = valid_q;
  assign PLL_RUNNING = run_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  mode_decode_a: assert property (##1 mode_q == $past({ctrl_q[CTRL_PLL_ON], ctrl_q[CTRL_MASTER]}))
    else $error("clock mode does not follow pll and master bits");
  ext_edges_a: assert property (!pll_run && !$changed(MASTER_CLOCK_INPUT) |=> $stable(phase))
    else $error("external mode phase moved without a master clock input edge");
  master_clock_output_low_a: assert property (!ctrl_q[CTRL_MASTER_CLOCK_OUTPUT_EN] |=> !MASTER_CLOCK_OUTPUT)
    else $error("master clock output not low while disabled");
  master_clock_input_gnd_a: assert property (pll_run && !ctrl_q[CTRL_MASTER] && ref_src == REF_FRM |-> status[ST_MASTER_CLOCK_INPUT_GND])
    else $error("grounded master clock input not flagged");
  master_drive_a: assert property (ctrl_q[CTRL_MASTER] |=> BIT_CLOCK_PIN_OE && FRAME_CLOCK_PIN_OE)
    else $error("master mode does not drive serial clocks");
  pdn_slave_a: assert property (!POWER_DOWN_PIN_N |=> !ctrl_q[CTRL_MASTER] ##1 !FRAME_CLOCK_PIN_OE)
    else $error("power down did not return to slave");
  pins_undriven_a: assert property (!ctrl_q[CTRL_MASTER] |=> !BIT_CLOCK_PIN_OE && !FRAME_CLOCK_PIN_OE)
    else $error("serial clock pins driven in slave mode");
  invalid_master_clock_output_a: assert property ((mode_q == EXT_MASTER && ctrl_q[CTRL_MASTER_CLOCK_OUTPUT_EN])[*2] |=>
    MASTER_CLOCK_OUTPUT != $past(MASTER_CLOCK_OUTPUT))
    else $error("no invalid clock on master clock output");
  analog_third_input_select_off_a: assert property (ctrl_q[CTRL_ANALOG_THIRD_INPUT_SELECT] |=> !PLL_RUNNING)
    else $error("pll running with third input selected");
  lock_wait_a: assert property (restart |-> ##2 !CLOCKS_VALID ##1 !CLOCKS_VALID)
    else $error("clocks valid before lock time");

  master_valid_c: cover property (mode_q == PLL_MASTER && CLOCKS_VALID);
  ext_master_c: cover property (mode_q == EXT_MASTER && BIT_CLOCK_PIN_OE);
  relock_c: cover property (restart ##1 !restart [*3]);
endmodule

// file: sim/acms_host.sv
// host model: serial clock source for slave modes, pull-downs on idle pins
`timescale 1ns/100ps
module acms_host
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control from the bench
  input wire logic drive_en,
  input wire logic master_clock_input_gnd,
  // device side of the pins
  input wire logic bck_o,
  input wire logic bck_oe,
  input wire logic frm_o,
  input wire logic frm_oe,
  // resolved pins
  output logic bck_pin,
  output logic frm_pin,
  output logic master_clock_input
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  always_comb
  begin
    cnt_d = cnt_q + 7'h01;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 7'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end
  // bit clock of 4 cycles, 32 per frame; undriven pins sit at the pull-down level
  assign bck_pin = bck_oe ? bck_o : (drive_en & cnt_q[1]);
  assign frm_pin = frm_oe ? frm_o : (drive_en & cnt_q[6]);
  assign master_clock_input = master_clock_input_gnd ? 1'b0 : cnt_q[0];
endmodule

// file: sim/tb_top.sv
// bench top: wishbone tasks, mode, decode, lock and pin checks
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import acms_pkg::*;
  typedef struct {string nm; logic [31:0] m; logic [31:0] e;} acms_note_t;
  localparam int LM = 15;
  int fail_count = 0;
  int total_checks = 0;
  acms_note_t notes[$];
  acms_note_t nt;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic pdn_n = 1'b1;
  logic host_en = 1'b1;
  logic gnd = 1'b0;
  logic [31:0] dat_o;
  logic ack, master_clock_input, master_clock_output, bck_pin, bck_o, bck_oe, frm_pin, frm_o, frm_oe, valid, pll_run;
  logic [1:0] mode;
  logic [1:0] rf;
  logic [7:0] lf = 8'h33;
  logic pv;
  int nb, nm, n, nc;
  always #2.5 clk = ~clk;
  acms_top #(.LOCK_FRM(20), .LOCK_BCK(10), .LOCK_MASTER_CLOCK_INPUT(LM)) acms_top_i (.CORE_CLK(clk), .RESET(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .POWER_DOWN_PIN_N(pdn_n), .MASTER_CLOCK_INPUT(master_clock_input),
    .MASTER_CLOCK_OUTPUT(master_clock_output), .BIT_CLOCK_PIN_I(bck_pin), .BIT_CLOCK_PIN_O(bck_o),
    .BIT_CLOCK_PIN_OE(bck_oe), .FRAME_CLOCK_PIN_I(frm_pin), .FRAME_CLOCK_PIN_O(frm_o),
    .FRAME_CLOCK_PIN_OE(frm_oe), .CLOCK_MODE(mode), .CLOCKS_VALID(valid), .PLL_RUNNING(pll_run));
  acms_host acms_host_i (.clk(clk), .rst(rst), .drive_en(host_en), .master_clock_input_gnd(gnd), .bck_o(bck_o),
    .bck_oe(bck_oe), .frm_o(frm_o), .frm_oe(frm_oe), .bck_pin(bck_pin), .frm_pin(frm_pin), .master_clock_input(master_clock_input));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [1:0] ref_of(input logic [3:0] c);
    if (c == 4'h0) return 2'h0;
    if (c == 4'h2 || c == 4'h3) return 2'h1;
    if ((c >= 4'h4 && c <= 4'h7) || c == 4'hc || c == 4'hd) return 2'h2;
    return 2'h3;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    sel <= s;
    @(posedge clk);
    // wait for ack however long it takes, only the watchdog ends a hang
    while (ack !== 1'b1)
    begin
      k++;
      @(posedge clk);
    end
    `CHK("ack latency", 1, k)
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string s);
    notes.push_back('{s, m, e & m});
    wb(1'b0, a, 32'h0, 4'hf);
  endtask
  // counts bit clock and master clock rises over one whole frame, and its length in cycles
  task automatic frame_count(output int b, output int m, output int c);
    int k;
    int t;
    logic pf;
    logic pb;
    logic pm;
    k = 0;
    t = 0;
    b = 0;
    m = 0;
    c = 0;
    pf = frm_o;
    pb = bck_o;
    pm = master_clock_output;
    while (k < 2 && t < 20000)
    begin
      @(posedge clk);
      t++;
      if (k == 1 && bck_o && !pb) b++;
      if (k == 1 && master_clock_output && !pm) m++;
      if (k == 1) c++;
      if (frm_o && !pf) k++;
      pf = frm_o;
      pb = bck_o;
      pm = master_clock_output;
    end
  endtask
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      `CHK(nt.nm, nt.e, dat_o & nt.m)
    end
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
  // ----------------
  // tests
  // ----------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0, 32'h7f, "ctrl");
    rd(ADDR_CLKSEL, 32'h0, 32'hff, "clksel");
    rd(ADDR_STATUS, 32'h0, 32'h3, "mode");
    `CHK("bck_oe", 1'b0, bck_oe)
    `CHK("frm_oe", 1'b0, frm_oe)
    lf = lfsr(lf);
    wb(1'b1, 8'h0c, {24'h0, lf}, 4'hf);
    wb(1'b1, ADDR_CLKSEL, {24'h0, lf}, 4'he);
    rd(8'h0c, 32'h0, 32'hffffffff, "unmapped");
    rd(ADDR_CLKSEL, 32'h0, 32'hff, "clksel lane");
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      host_en <= ~i[0];
      wr(ADDR_CTRL, {30'h0, i[0], i[1]});
      repeat (3) @(posedge clk);
      rd(ADDR_STATUS, i, 32'h3, "status mode");
      `CHK("clock_mode", i[1:0], mode)
      `CHK("bck_oe", i[0], bck_oe)
      `CHK("frm_oe", i[0], frm_oe)
      repeat (8)
      begin
        @(posedge clk);
        `CHK("master_clock_output off", 1'b0, master_clock_output)
      end
    end
    wr(ADDR_CTRL, 32'h6);
    repeat (3) @(posedge clk);
    pv = master_clock_output;
    n = 0;
    repeat (4)
    begin
      @(posedge clk);
      if (master_clock_output !== pv) n++;
      pv = master_clock_output;
    end
    `CHK("master_clock_output invalid", 4, n)
    $display("test modes done");
    host_en <= 1'b1;
    wr(ADDR_CTRL, 32'h1);
    for (int c = 0; c < 16; c++)
    begin
      rf = ref_of(c[3:0]);
      gnd <= rf < 2'h2;
      wr(ADDR_CLKSEL, c);
      rd(ADDR_STATUS, {25'h0, rf == 2'h3, rf < 2'h2, rf, 3'h0}, 32'h78, "ref");
    end
    for (int c = 0; c < 32; c++)
    begin
      gnd <= ~c[4];
      wr(ADDR_CLKSEL, {24'h0, c[3:0], c[4] ? 4'h4 : 4'h0});
      pv = c[4] ? (c[3:0] inside {4'h8, 4'h9, 4'hc, 4'hd}) : (c[3] & ~c[1]);
      rd(ADDR_STATUS, {25'h0, pv, 6'h0}, 32'h40, "rate code");
    end
    gnd <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CLKSEL, 32'h81);
    rd(ADDR_STATUS, 32'h0, 32'h40, "ext unused");
    wr(ADDR_CTRL, 32'h9);
    repeat (3) @(posedge clk);
    `CHK("pll_run analog_third_input_select", 1'b0, pll_run)
    wr(ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("pll_run", 1'b1, pll_run)
    $display("test decode done");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CLKSEL, 32'hb5);
    host_en <= 1'b0;
    wr(ADDR_CTRL, 32'h67);
    repeat (3) @(posedge clk);
    `CHK("valid unlocked", 1'b0, valid)
    n = 3;
    pv = master_clock_output;
    while (valid !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
      if (n == 5)
      begin
        `CHK("bck low unlocked", 1'b0, bck_o)
        `CHK("master_clock_output toggle", ~pv, master_clock_output)
      end
      pv = master_clock_output;
    end
    `CHK("lock time", 1'b1, n >= LM - 2 && n <= LM + 5)
    frame_count(nb, nm, nc);
    `CHK("bits per frame", 32, nb)
    `CHK("master_clock_output per frame", 32, nm)
    wr(ADDR_CTRL, 32'h77);
    frame_count(nb, nm, nc);
    `CHK("bits per frame 64", 64, nb)
    $display("test lock done");
    // external master, rate bits 0101 ask for 1024fs; the reference field must not matter
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_CLKSEL, 32'h5d);
    frame_count(nb, nm, nc);
    `CHK("ext bits per frame", 32, nb)
    `CHK("ext frame cycles", 2 * 1024, nc)
    `CHK("ext master_clock_output off", 0, nm)
    $display("test external done");
    pdn_n <= 1'b0;
    @(posedge clk);
    pdn_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("bck_oe pdn", 1'b0, bck_oe)
    `CHK("mode pdn", 2'h0, mode)
    host_en <= 1'b1;
    rd(ADDR_CTRL, 32'h0, 32'h7f, "ctrl pdn");
    $display("test power down done");
    conclude();
  end
endmodule
